// >>> verilog/chip_mode_defs.svh
// Constants for the status word, chip mode control and register map
`ifndef CHIP_MODE_DEFS_SVH
`define CHIP_MODE_DEFS_SVH
// Status word field positions and reset value
`define PSW_PARITY_BIT   0
`define PSW_OV_BIT       2
`define PSW_RS0_BIT      3
`define PSW_RS1_BIT      4
`define PSW_AC_BIT       6
`define PSW_CY_BIT       7
`define PSW_RESET        8'h00
// Register byte offsets on the bus
`define OFS_PSW          15'h0000
`define OFS_MODE_CTRL    15'h0004
`define OFS_UNLOCK       15'h0008
`define OFS_MODE_STAT    15'h000c
`define OFS_BANK_BASE    15'h0010
// Memory windows: window number, compared with the upper address bits
`define WIN_IDATA        5'h01
`define WIN_EXTRA_ON_CHIP_RAM         5'h02
`define WIN_BOOT_ROM_HI  1'h1
`define MODE_CTRL_RESET  2'h0
// Unlock keys written back to back to the unlock register
`define UNLOCK_KEY1      8'h9b
`define UNLOCK_KEY2      8'h64
// Sizes of the on-chip memories
`define IDATA_BYTES      256
`define EXTRA_ON_CHIP_RAM_BYTES       256
`define SFR_BYTES        128
`define BOOT_ROM_BYTES   4096
`define BOOT_ROM_FILL    8'hff
// Address boundaries of the code and data spaces
`define ROMRAM_TOP       16'h1fff
`define BOOT_ROM_TOP     16'h0fff
`define EXTRA_ON_CHIP_RAM_BASE        16'hff00
`endif

// >>> verilog/chip_mode_pkg.sv
// Types shared by the chip mode and memory map logic
package chip_mode_pkg;
   // Mode code is {boot enable, swap}
   typedef enum logic [1:0] {
      MODE_NORMAL      = 2'b00,
      MODE_NORMAL_EXTRA_ON_CHIP_RAM = 2'b01,
      MODE_BOOT        = 2'b10,
      MODE_BOOT_EXTRA_ON_CHIP_RAM   = 2'b11
   } chip_mode_t;
   typedef enum logic [1:0] {
      SPACE_NONE   = 2'b00,
      SPACE_ROMRAM = 2'b01,
      SPACE_BOOT   = 2'b10,
      SPACE_EXTRA_ON_CHIP_RAM   = 2'b11
   } space_t;
   typedef enum logic [0:0] {
      UNL_IDLE = 1'b0,
      UNL_KEY1 = 1'b1
   } unlock_t;
endpackage : chip_mode_pkg

// >>> verilog/status_word.sv
// Processor status word with hardware flag updates and parity
`timescale 1ns/100ps
`include "chip_mode_defs.svh"
module status_word (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       sw_we_i,
   input  wire logic [7:0] sw_data_i,
   input  wire logic       instr_done_i,
   input  wire logic [7:0] acc_i,
   input  wire logic       cy_we_i,
   input  wire logic       cy_i,
   input  wire logic       ac_we_i,
   input  wire logic       ac_i,
   input  wire logic       ov_we_i,
   input  wire logic       ov_i,
   output logic      [7:0] psw_o
);
   logic [7:0] psw_nxt;

   // Hardware updates beat a software write in the same cycle
   always_comb begin
      psw_nxt = psw_o;
      if (sw_we_i) begin
         psw_nxt = sw_data_i;
         psw_nxt[`PSW_PARITY_BIT] = psw_o[`PSW_PARITY_BIT]; // Parity is not writable
      end
      if (cy_we_i) psw_nxt[`PSW_CY_BIT] = cy_i;
      if (ac_we_i) psw_nxt[`PSW_AC_BIT] = ac_i;
      if (ov_we_i) psw_nxt[`PSW_OV_BIT] = ov_i;
      if (instr_done_i) psw_nxt[`PSW_PARITY_BIT] = ^acc_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) psw_o <= `PSW_RESET;
      else psw_o <= psw_nxt;
   end

   property p_parity;
      @(posedge clk_i) disable iff (!rst_n_i)
      instr_done_i |=> (^{psw_o[`PSW_PARITY_BIT], $past(acc_i)}) == 1'b0;
   endproperty
   a_parity: assert property (p_parity) else $error("parity not even");
   property p_carry_hw;
      @(posedge clk_i) disable iff (!rst_n_i)
      cy_we_i |=> psw_o[`PSW_CY_BIT] == $past(cy_i);
   endproperty
   a_carry_hw: assert property (p_carry_hw) else $error("carry not updated");
endmodule : status_word

// >>> verilog/space_decode.sv
// Classifies code and data addresses by the active chip mode
`timescale 1ns/100ps
`include "chip_mode_defs.svh"
module space_decode
   import chip_mode_pkg::*;
(
   input  wire chip_mode_t  mode_i,
   input  wire logic [15:0] code_addr_i,
   input  wire logic [15:0] data_addr_i,
   output space_t           code_sel_o,
   output space_t           data_sel_o
);
   logic in_romram_c, in_boot_c, in_extra_on_chip_ram_c, in_romram_d, in_extra_on_chip_ram_d;

   // Region hits for both spaces
   always_comb begin
      in_romram_c = code_addr_i <= `ROMRAM_TOP;
      in_boot_c   = code_addr_i <= `BOOT_ROM_TOP;
      in_extra_on_chip_ram_c   = code_addr_i >= `EXTRA_ON_CHIP_RAM_BASE;
      in_romram_d = data_addr_i <= `ROMRAM_TOP;
      in_extra_on_chip_ram_d   = data_addr_i >= `EXTRA_ON_CHIP_RAM_BASE;
   end

   // Per-mode mapping; unmapped addresses select nothing
   always_comb begin
      code_sel_o = SPACE_NONE;
      data_sel_o = SPACE_NONE;
      case (mode_i)
         MODE_NORMAL: begin
            if (in_romram_c) code_sel_o = SPACE_ROMRAM;
            if (in_extra_on_chip_ram_d) data_sel_o = SPACE_EXTRA_ON_CHIP_RAM;
         end
         MODE_BOOT: begin
            if (in_boot_c) code_sel_o = SPACE_BOOT;
            if (in_extra_on_chip_ram_d) data_sel_o = SPACE_EXTRA_ON_CHIP_RAM;
            else if (in_romram_d) data_sel_o = SPACE_ROMRAM;
         end
         MODE_NORMAL_EXTRA_ON_CHIP_RAM: begin
            if (in_extra_on_chip_ram_c) code_sel_o = SPACE_EXTRA_ON_CHIP_RAM;
            if (in_romram_d) data_sel_o = SPACE_ROMRAM;
         end
         MODE_BOOT_EXTRA_ON_CHIP_RAM: begin
            if (in_boot_c) code_sel_o = SPACE_BOOT;
            else if (in_extra_on_chip_ram_c) code_sel_o = SPACE_EXTRA_ON_CHIP_RAM;
            if (in_romram_d) data_sel_o = SPACE_ROMRAM;
         end
         default: begin
            code_sel_o = SPACE_NONE;
            data_sel_o = SPACE_NONE;
         end
      endcase
   end
endmodule : space_decode

// >>> verilog/chip_mode_top.sv
// Status word, chip mode selection, memory map and Avalon register slave
`timescale 1ns/100ps
`include "chip_mode_defs.svh"
module chip_mode_top
   import chip_mode_pkg::*;
#(
   parameter int IDATA_BYTES = `IDATA_BYTES,
   parameter int EXTRA_ON_CHIP_RAM_BYTES  = `EXTRA_ON_CHIP_RAM_BYTES,
   parameter int ROM_BYTES   = `BOOT_ROM_BYTES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        boot_strap_pin_i,
   input  wire logic [14:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        instr_done_i,
   input  wire logic [7:0]  acc_i,
   input  wire logic        cy_we_i,
   input  wire logic        cy_i,
   input  wire logic        ac_we_i,
   input  wire logic        ac_i,
   input  wire logic        ov_we_i,
   input  wire logic        ov_i,
   input  wire logic [15:0] code_addr_i,
   input  wire logic [15:0] data_addr_i,
   input  wire logic [7:0]  dir_addr_i,
   output logic      [7:0]  psw_o,
   output logic      [4:0]  bank_base_o,
   output chip_mode_t       mode_o,
   output space_t           code_sel_o,
   output space_t           data_sel_o,
   output logic             sfr_sel_o
);
   logic            rst_meta_r, rst_n;
   logic [7:0]      idata_mem [0:IDATA_BYTES-1];
   logic [7:0]      extra_on_chip_ram_mem  [0:EXTRA_ON_CHIP_RAM_BYTES-1];
   logic [7:0]      boot_rom  [0:ROM_BYTES-1];
   logic [1:0]      mode_ctrl_r;
   unlock_t         unlock_r;
   logic            strap_done_r, strap_boot_r;
   logic            acc_go, wr_go, unlock_fire;
   logic            psw_we;
   logic [31:0]     rd_nxt;
   space_t          code_sel_nxt, data_sel_nxt;
   logic [7:0]      wbyte;

   // Bank base address from the two select bits
   function automatic logic [4:0] bank_base(input logic [7:0] processor_status_word);
      return {processor_status_word[`PSW_RS1_BIT], processor_status_word[`PSW_RS0_BIT], 3'h0};
   endfunction

   // True when the address falls in the given 1 Kbyte window
   function automatic logic in_win(input logic [14:0] a, input logic [4:0] w);
      return a[14:10] == w;
   endfunction

   // Reset release through two flip-flops; assertion stays asynchronous
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Boot ROM image; erased pattern until a loader image is substituted
   initial begin
      for (int i = 0; i < ROM_BYTES; i++) boot_rom[i] = `BOOT_ROM_FILL;
   end

   // One wait cycle per access: the answer is registered before release
   assign acc_go = (avs_read_i || avs_write_i) && avs_waitrequest_o;
   assign wr_go  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign wbyte  = avs_writedata_i[7:0];
   assign psw_we = wr_go && avs_address_i == `OFS_PSW;
   assign unlock_fire = wr_go && avs_address_i == `OFS_UNLOCK
                        && unlock_r == UNL_KEY1 && wbyte == `UNLOCK_KEY2;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) avs_waitrequest_o <= 1'b1;
      else avs_waitrequest_o <= !acc_go;
   end

   // Read multiplexer over registers and memory windows
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (avs_address_i[14] == `WIN_BOOT_ROM_HI)
         rd_nxt[7:0] = boot_rom[avs_address_i[13:2]];
      else if (in_win(avs_address_i, `WIN_IDATA))
         rd_nxt[7:0] = idata_mem[avs_address_i[9:2]];
      else if (in_win(avs_address_i, `WIN_EXTRA_ON_CHIP_RAM))
         rd_nxt[7:0] = extra_on_chip_ram_mem[avs_address_i[9:2]];
      else begin
         case (avs_address_i)
            `OFS_PSW:       rd_nxt[7:0] = psw_o;
            `OFS_MODE_CTRL: rd_nxt[1:0] = mode_ctrl_r;
            `OFS_UNLOCK:    rd_nxt[0]   = unlock_r;
            `OFS_MODE_STAT: rd_nxt[3:0] = {strap_done_r, strap_boot_r, mode_o};
            `OFS_BANK_BASE: rd_nxt[4:0] = bank_base_o;
            default:        rd_nxt      = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) avs_readdata_o <= 32'h0000_0000;
      else if (acc_go && avs_read_i) avs_readdata_o <= rd_nxt;
   end

   // Memory writes; the boot ROM window ignores writes
   always_ff @(posedge ref_clk_i) begin
      if (wr_go && avs_address_i[14] != `WIN_BOOT_ROM_HI) begin
         if (in_win(avs_address_i, `WIN_IDATA)) idata_mem[avs_address_i[9:2]] <= wbyte;
         if (in_win(avs_address_i, `WIN_EXTRA_ON_CHIP_RAM)) extra_on_chip_ram_mem[avs_address_i[9:2]] <= wbyte;
      end
   end

   // Pending mode bits; they do not touch the mapping by themselves
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) mode_ctrl_r <= `MODE_CTRL_RESET;
      else if (wr_go && avs_address_i == `OFS_MODE_CTRL) mode_ctrl_r <= wbyte[1:0];
   end

   // Unlock: two keys in consecutive writes; any other write starts over
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) unlock_r <= UNL_IDLE;
      else if (wr_go) begin
         case (unlock_r)
            UNL_IDLE: begin
               if (avs_address_i == `OFS_UNLOCK && wbyte == `UNLOCK_KEY1)
                  unlock_r <= UNL_KEY1;
            end
            UNL_KEY1: unlock_r <= UNL_IDLE; // Completed or broken
            default:  unlock_r <= UNL_IDLE;
         endcase
      end
   end

   // Strap sampled once at the first clock after reset release
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_r <= 1'b0;
         strap_boot_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         strap_boot_r <= !boot_strap_pin_i;
      end
   end

   // Active mode: strap at release, later only through a completed unlock
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) mode_o <= MODE_NORMAL;
      else if (!strap_done_r) mode_o <= boot_strap_pin_i ? MODE_NORMAL : MODE_BOOT;
      else if (unlock_fire) mode_o <= chip_mode_t'(mode_ctrl_r);
   end

   status_word u_status (
      .clk_i        (ref_clk_i),
      .rst_n_i      (rst_n),
      .sw_we_i      (psw_we),
      .sw_data_i    (wbyte),
      .instr_done_i (instr_done_i),
      .acc_i        (acc_i),
      .cy_we_i      (cy_we_i),
      .cy_i         (cy_i),
      .ac_we_i      (ac_we_i),
      .ac_i         (ac_i),
      .ov_we_i      (ov_we_i),
      .ov_i         (ov_i),
      .psw_o        (psw_o)
   );

   space_decode u_decode (
      .mode_i      (mode_o),
      .code_addr_i (code_addr_i),
      .data_addr_i (data_addr_i),
      .code_sel_o  (code_sel_nxt),
      .data_sel_o  (data_sel_nxt)
   );

   // Registered map outputs; one cycle behind the addresses
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         code_sel_o  <= SPACE_NONE;
         data_sel_o  <= SPACE_NONE;
         bank_base_o <= 5'h00;
         sfr_sel_o   <= 1'b0;
      end else begin
         code_sel_o  <= code_sel_nxt;
         data_sel_o  <= data_sel_nxt;
         bank_base_o <= bank_base(psw_o);
         sfr_sel_o   <= dir_addr_i[7];    // Upper half is SFR space
      end
   end

   // Mode entry, map and bus timing checks; each starts once the reset copy is high
   property p_bank;
      @(posedge ref_clk_i) disable iff (!rst_n)
      rst_n |=> bank_base_o == {$past(psw_o[`PSW_RS1_BIT]), $past(psw_o[`PSW_RS0_BIT]), 3'h0};
   endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong");
   property p_sw_normal;
      @(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b00 |=> mode_o == MODE_NORMAL;
   endproperty
   a_sw_normal: assert property (p_sw_normal) else $error("normal not entered");
   property p_sw_boot;
      @(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b10 |=> mode_o == MODE_BOOT ##1 code_sel_o != SPACE_ROMRAM;
   endproperty
   a_sw_boot: assert property (p_sw_boot) else $error("boot not entered");
   property p_sw_nxram;
      @(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b01 |=> mode_o == MODE_NORMAL_EXTRA_ON_CHIP_RAM;
   endproperty
   a_sw_nxram: assert property (p_sw_nxram) else $error("normal extra_on_chip_ram not entered");
   property p_sw_bxram;
      @(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b11 |=> mode_o == MODE_BOOT_EXTRA_ON_CHIP_RAM;
   endproperty
   a_sw_bxram: assert property (p_sw_bxram) else $error("boot extra_on_chip_ram not entered");
   property p_abort;
      @(posedge ref_clk_i) disable iff (!rst_n)
      !strap_done_r |-> unlock_r == UNL_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("unlock survived reset");
   property p_sfr;
      @(posedge ref_clk_i) disable iff (!rst_n)
      rst_n |=> sfr_sel_o == $past(dir_addr_i[7]);
   endproperty
   a_sfr: assert property (p_sfr) else $error("sfr decode wrong");
   property p_strap;
      @(posedge ref_clk_i) disable iff (!rst_n)
      rst_n && !strap_done_r |=> mode_o == ($past(boot_strap_pin_i) ? MODE_NORMAL : MODE_BOOT);
   endproperty
   a_strap: assert property (p_strap) else $error("strap mode wrong");
   property p_hold;
      @(posedge ref_clk_i) disable iff (!rst_n)
      strap_done_r && !unlock_fire |=> mode_o == $past(mode_o);
   endproperty
   a_hold: assert property (p_hold) else $error("mode changed unlocked");
   property p_wait;
      @(posedge ref_clk_i) disable iff (!rst_n)
      acc_go |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

   // Map, unlock and read data checks
   // The map outputs lag the mode by one edge, so map checks look one edge on
   property p_nxram_map;
      @(posedge ref_clk_i) disable iff (!rst_n)
      mode_o == MODE_NORMAL_EXTRA_ON_CHIP_RAM |=> code_sel_o inside {SPACE_EXTRA_ON_CHIP_RAM, SPACE_NONE}
         && data_sel_o inside {SPACE_ROMRAM, SPACE_NONE};
   endproperty
   a_nxram_map: assert property (p_nxram_map) else $error("normal extra_on_chip_ram map wrong");
   property p_boot_code;
      @(posedge ref_clk_i) disable iff (!rst_n)
      mode_o inside {MODE_NORMAL, MODE_NORMAL_EXTRA_ON_CHIP_RAM} |=> code_sel_o != SPACE_BOOT;
   endproperty
   a_boot_code: assert property (p_boot_code) else $error("boot rom outside boot modes");
   property p_unlock_clear;
      @(posedge ref_clk_i) disable iff (!rst_n)
      unlock_r == UNL_KEY1 && wr_go |=> unlock_r == UNL_IDLE;
   endproperty
   a_unlock_clear: assert property (p_unlock_clear) else $error("unlock stage kept");
   property p_rd_hold;
      @(posedge ref_clk_i) disable iff (!rst_n)
      !(acc_go && avs_read_i) |=> $stable(avs_readdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

   // Scenarios worth seeing in coverage

   c_nxram: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b01);
   c_strap_boot: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      !strap_done_r && !boot_strap_pin_i);
   c_bank3: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      bank_base_o == 5'h18);
   c_sw_boot: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b10);
   c_bxram: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      unlock_fire && mode_ctrl_r == 2'b11);
endmodule : chip_mode_top

// >>> tb/chip_mode_memory_map_status_word_bench.sv
// Self-checking bench for the status word, chip mode selection and memory map
`timescale 1ns/100ps
`include "chip_mode_defs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module chip_mode_memory_map_status_word_bench;
   import chip_mode_pkg::*;
   logic        ref_clk_i, nrst_i, boot_strap_pin_i;
   logic [14:0] avs_address_i;
   logic        avs_read_i, avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        instr_done_i, cy_we_i, cy_i, ac_we_i, ac_i, ov_we_i, ov_i;
   logic [7:0]  acc_i, dir_addr_i, psw_o, exp_psw, v;
   logic [15:0] code_addr_i, data_addr_i;
   logic [4:0]  bank_base_o;
   chip_mode_t  mode_o;
   space_t      code_sel_o, data_sel_o;
   logic        sfr_sel_o;
   logic [31:0] q;
   logic [2:0]  e;
   int          fails, tests_run, seed;

   chip_mode_top uut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .boot_strap_pin_i(boot_strap_pin_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .instr_done_i(instr_done_i), .acc_i(acc_i), .cy_we_i(cy_we_i), .cy_i(cy_i),
      .ac_we_i(ac_we_i), .ac_i(ac_i), .ov_we_i(ov_we_i), .ov_i(ov_i),
      .code_addr_i(code_addr_i), .data_addr_i(data_addr_i), .dir_addr_i(dir_addr_i),
      .psw_o(psw_o), .bank_base_o(bank_base_o), .mode_o(mode_o),
      .code_sel_o(code_sel_o), .data_sel_o(data_sel_o), .sfr_sel_o(sfr_sel_o)
   );

   // 50 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // Prints the counts and the verdict, then stops
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // Hang guard well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      conclude();
   end

   // Reset held 3 cycles; waits until the bus may be used again
   task automatic do_reset(input logic strap);
      boot_strap_pin_i <= strap;
      nrst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
   endtask : do_reset

   // One Avalon access; held until waitrequest is sampled low, then an idle edge
   task automatic bus(input logic wr, input logic [14:0] a, input logic [7:0] d,
                      output logic [31:0] rd);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= {24'h000000, d};
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask : bus

   // Full unlock: mode bits, then both keys with no other write between
   task automatic set_mode(input logic [1:0] m);
      bus(1'b1, `OFS_MODE_CTRL, {6'h00, m}, q);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY1, q);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY2, q);
      repeat (2) @(posedge ref_clk_i);
   endtask : set_mode

   // Expected space class: {known, space}; none where the map says nothing
   function automatic logic [2:0] exp_sel(input logic [1:0] m, input bit is_code,
                                          input logic [15:0] a);
      logic boot, rr, hi;
      boot = (a <= `BOOT_ROM_TOP);
      rr = (a <= `ROMRAM_TOP);
      hi = (a >= `EXTRA_ON_CHIP_RAM_BASE);
      if (is_code) begin
         if (hi && m[0]) return {1'b1, SPACE_EXTRA_ON_CHIP_RAM};
         if (boot && m[1]) return {1'b1, SPACE_BOOT};
         if (rr && m == MODE_NORMAL) return {1'b1, SPACE_ROMRAM};
      end else begin
         if (hi && !m[0]) return {1'b1, SPACE_EXTRA_ON_CHIP_RAM};
         if (rr && m != MODE_NORMAL) return {1'b1, SPACE_ROMRAM};
      end
      return {1'b1, SPACE_NONE};
   endfunction : exp_sel

   initial begin
      seed = 61205;
      fails = 0;
      tests_run = 0;
      nrst_i = 1'b0;
      boot_strap_pin_i = 1'b1;
      {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
      avs_byteenable_i = 4'hf;
      {instr_done_i, cy_we_i, cy_i, ac_we_i, ac_i, ov_we_i, ov_i} = '0;
      acc_i = 8'h00;
      dir_addr_i = 8'h00;
      code_addr_i = 16'h0000;
      data_addr_i = 16'h0000;
      do_reset(1'b1);
      `CHK(psw_o, `PSW_RESET)
      `CHK(mode_o, MODE_NORMAL)
      do_reset(1'b0);
      `CHK(mode_o, MODE_BOOT)
      bus(1'b0, `OFS_MODE_STAT, 8'h00, q);
      `CHK(q, {28'h0000000, 1'b1, 1'b1, MODE_BOOT})
      // Core flag updates and parity, random accumulator and write enables
      exp_psw = 8'h00;
      repeat (40) begin
         v = 8'($random(seed));
         acc_i <= 8'($random(seed));
         instr_done_i <= 1'b1;
         {cy_we_i, cy_i, ac_we_i, ac_i, ov_we_i, ov_i} <= v[5:0];
         @(posedge ref_clk_i);
         if (v[5]) exp_psw[7] = v[4];
         if (v[3]) exp_psw[6] = v[2];
         if (v[1]) exp_psw[2] = v[0];
         exp_psw[0] = ^acc_i;
         {instr_done_i, cy_we_i, ac_we_i, ov_we_i} <= 4'h0;
         @(posedge ref_clk_i);
         `CHK(psw_o, exp_psw)
      end
      // Software writes of the whole word, every bank select value
      for (int b = 0; b < 4; b++) begin
         v = 8'($random(seed));
         v[4:3] = b[1:0];
         bus(1'b1, `OFS_PSW, v, q);
         exp_psw = {v[7:1], exp_psw[0]};
         repeat (2) @(posedge ref_clk_i);
         `CHK(psw_o, exp_psw)
         `CHK(bank_base_o, {b[1:0], 3'b000})
         bus(1'b0, `OFS_PSW, 8'h00, q);
         `CHK(q, {24'h000000, exp_psw})
      end
      // A write with the low byte lane off must leave the word alone
      avs_byteenable_i <= 4'he;
      bus(1'b1, `OFS_PSW, ~exp_psw, q);
      avs_byteenable_i <= 4'hf;
      bus(1'b0, `OFS_PSW, 8'h00, q);
      `CHK(q, {24'h000000, exp_psw})
      // Every mode by software, then the map checked at random addresses
      for (int m = 3; m >= 0; m--) begin
         set_mode(m[1:0]);
         `CHK(mode_o, m[1:0])
         repeat (6) begin
            code_addr_i <= ($random(seed) & 1) ? (16'hff00 | 16'($random(seed) & 8'hff))
                                                : 16'($random(seed) & 16'h1fff);
            data_addr_i <= ($random(seed) & 1) ? (16'hff00 | 16'($random(seed) & 8'hff))
                                                : 16'($random(seed) & 16'h1fff);
            repeat (2) @(posedge ref_clk_i);
            e = exp_sel(m[1:0], 1'b1, code_addr_i);
            if (e[2]) `CHK(code_sel_o, e[1:0])
            e = exp_sel(m[1:0], 1'b0, data_addr_i);
            if (e[2]) `CHK(data_sel_o, e[1:0])
         end
      end
      // Broken sequence: a wrong write between the keys leaves the mode alone
      bus(1'b1, `OFS_MODE_CTRL, 8'h01, q);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY1, q);
      bus(1'b1, `OFS_UNLOCK, 8'h00, q);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY2, q);
      repeat (2) @(posedge ref_clk_i);
      `CHK(mode_o, MODE_NORMAL)
      // Reset between the keys must drop the half-done sequence
      bus(1'b1, `OFS_MODE_CTRL, 8'h03, q);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY1, q);
      do_reset(1'b0);
      bus(1'b1, `OFS_UNLOCK, `UNLOCK_KEY2, q);
      repeat (2) @(posedge ref_clk_i);
      `CHK(mode_o, MODE_BOOT)
      // Separate data memories, top word included; boot ROM and a hole
      for (int k = 0; k < 8; k++) begin
         automatic logic [7:0] idx = (k == 0) ? 8'hff : 8'($random(seed));
         automatic logic [7:0] d1 = 8'($random(seed));
         bus(1'b1, 15'(`WIN_IDATA * 1024 + idx * 4), d1, q);
         bus(1'b1, 15'(`WIN_EXTRA_ON_CHIP_RAM * 1024 + idx * 4), ~d1, q);
         bus(1'b0, 15'(`WIN_IDATA * 1024 + idx * 4), 8'h00, q);
         `CHK(q, {24'h000000, d1})
         bus(1'b0, 15'(`WIN_EXTRA_ON_CHIP_RAM * 1024 + idx * 4), 8'h00, q);
         `CHK(q, {24'h000000, ~d1})
      end
      bus(1'b1, 15'h7ffc, 8'h12, q);
      bus(1'b0, 15'h7ffc, 8'h00, q);
      `CHK(q, {24'h000000, `BOOT_ROM_FILL})
      bus(1'b0, 15'h4000, 8'h00, q);
      `CHK(q, {24'h000000, `BOOT_ROM_FILL})
      bus(1'b0, 15'h3000, 8'h00, q);
      `CHK(q, 32'h00000000)
      // Direct addresses split at 80h into the register area
      repeat (20) begin
         dir_addr_i <= 8'($random(seed));
         @(posedge ref_clk_i);
         @(posedge ref_clk_i);
         `CHK(sfr_sel_o, dir_addr_i[7])
      end
      conclude();
   end
endmodule : chip_mode_memory_map_status_word_bench
